// file: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, gt) \
    begin \
        cmp_count++; \
        if ((gt) !== (ex)) \
        begin \
            errors++; \
            $display("mismatch %s expected %h seen %h", nm, ex, gt); \
        end \
    end

module tb;
    import rac_pkg::*;

    // ****************************************
    // signals
    // ****************************************
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic xtal = 1'b0;
    rac_time_t time_v = '0;
    logic half_sec;
    logic second;
    logic alarm_irq;
    logic alarm_pulse;
    int errors = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic er;

    // ****************************************
    // clock, crystal and design
    // ****************************************
    always #25 ref_clk = ~ref_clk;

    // crystal toggles every clock, one rising edge per two clocks
    always @(posedge ref_clk)
    begin
        xtal <= ~xtal;
    end

    rac_alarm_cal dut
    (
        .REF_CLK_I(ref_clk),
        .RESETN_I(resetn),
        .PSEL_I(psel),
        .PENABLE_I(penable),
        .PWRITE_I(pwrite),
        .PADDR_I(paddr),
        .PWDATA_I(pwdata),
        .PRDATA_O(prdata),
        .PREADY_O(pready),
        .PSLVERR_O(pslverr),
        .XTAL_I(xtal),
        .TIME_I(time_v),
        .HALF_SEC_O(half_sec),
        .SECOND_O(second),
        .ALARM_IRQ_O(alarm_irq),
        .ALARM_PULSE_O(alarm_pulse)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // apb transfer, held until pready seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK("pready", 1'b1, pready)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input logic ex_err);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("read data", ex, rd)
        `CHK("read error", ex_err, er)
    endtask

    // wait for a half second tick and check the alarm that follows
    task automatic tick(input logic ex_sec);
        int n;
        logic pulse_before;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (half_sec !== 1'b1 && n < 40000);
        `CHK("second tick", ex_sec, second)
        pulse_before = alarm_pulse;
        @(negedge ref_clk);
        `CHK("irq early", 1'b0, alarm_irq)
        @(negedge ref_clk);
        `CHK("alarm irq", 1'b1, alarm_irq)
        `CHK("alarm pulse", ~pulse_before, alarm_pulse)
        @(negedge ref_clk);
        `CHK("irq one cycle", 1'b0, alarm_irq)
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_chk(ADDR_ALARM_CFG, 32'h0000_0000, 1'b0);
        apb(1'b1, ADDR_ALARM_WDH, 32'hFFFF_FEE3);
        rd_chk(ADDR_ALARM_WDH, 32'h0000_0000, 1'b0);
        apb(1'b1, ADDR_CLOCK_CFG, 32'h0000_C0FC);
        rd_chk(ADDR_CLOCK_CFG, 32'h0000_C0FC, 1'b0);
        apb(1'b1, ADDR_ALARM_WDH, 32'hFFFF_FEE3);
        rd_chk(ADDR_ALARM_WDH, 32'h0000_0623, 1'b0);
        apb(1'b1, ADDR_ALARM_MS, 32'hFFFF_D9A5);
        rd_chk(ADDR_ALARM_MS, 32'h0000_5925, 1'b0);
        rd_chk(8'h14, 32'h0000_0000, 1'b1);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        `CHK("unmapped write error", 1'b1, er)
        apb(1'b1, ADDR_ALARM_CFG, 32'h0000_C000);
        rd_chk(ADDR_ALARM_CFG, 32'h0000_C000, 1'b0);
        $display("test registers done");

        tick(1'b0);
        rd_chk(ADDR_ALARM_CFG, 32'h0000_C0FF, 1'b0);
        apb(1'b1, ADDR_ALARM_CFG, 32'h0000_8801);
        time_v.second_ones <= 4'h5;
        time_v.second_tens <= 3'h3;
        $display("test endless repeat done");

        tick(1'b1);
        rd_chk(ADDR_ALARM_CFG, 32'h0000_8800, 1'b0);
        apb(1'b1, ADDR_ALARM_CFG, 32'h0000_8000);
        $display("test masked match done");

        tick(1'b0);
        rd_chk(ADDR_ALARM_CFG, 32'h0000_0000, 1'b0);
        $display("test final alarm done");
        give_verdict();
    end

    // ****************************************
    // watchdog
    // ****************************************
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        $display("watchdog expired");
        give_verdict();
    end

endmodule

`default_nettype wire

// file: core/rac_alarm_cal.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - weekday kept as three bits 10:8, values 0 to 6
// - hour tens in bits 5:4, hour ones in bits 3:0
// - weekday/hour writes accepted only while calendar_write_enable is 1
// - minute tens bits 14:12, minute ones bits 11:8
// - second tens bits 6:4, second ones bits 3:0
// - unimplemented alarm value bits read back as zero
// - signed calibration byte times four applied to prescaler each minute
// - negative value removes pulses, positive value adds pulses
// - alarm enabled by bit 15 of alarm configuration
// - mask bits 13:10 choose which digits must match
// - repeat count 00h without endless_repeat gives a single alarm
// - repeat count decrements per alarm; at 00h last alarm clears enable
// - endless_repeat bit 14 wraps repeat count 00h to FFh, endless alarms
// - every alarm raises an interrupt request
// - alarm pulse output toggles per alarm, synchronous to REF_CLK_I
// - mask codes 0000 to 1001 give half second to year intervals
module rac_alarm_cal
    import rac_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESETN_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // crystal and time
    input wire logic XTAL_I,
    input wire rac_pkg::rac_time_t TIME_I,
    output logic HALF_SEC_O,
    output logic SECOND_O,
    // alarm
    output logic ALARM_IRQ_O,
    output logic ALARM_PULSE_O
);
    import rac_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic xtal_rise;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic en_ff, nxt_en;
    logic endless_repeat_ff, nxt_endless_repeat;
    logic [3:0] mask_ff, nxt_mask;
    logic [7:0] rpt_ff, nxt_rpt;
    logic wren_ff, nxt_wren;
    logic ton_ff, nxt_ton;
    logic [7:0] cal_ff, nxt_cal;
    logic [15:0] md_ff, nxt_md;
    logic [15:0] wdh_ff, nxt_wdh;
    logic [15:0] ms_ff, nxt_ms;
    logic [15:0] presc_ff, nxt_presc;
    logic phase_ff, nxt_phase;
    logic [5:0] sec_cnt_ff, nxt_sec_cnt;
    logic half_ff, nxt_half;
    logic sec_ff, nxt_sec;
    logic eval_ff, nxt_eval;
    logic eval_sec_ff, nxt_eval_sec;
    logic irq_ff, nxt_irq;
    logic pulse_ff, nxt_pulse;
    logic sync_stat;
    logic wr_now;
    logic match;
    logic [16:0] reload;

    rac_pin_sync u_xtal_sync
    (
        .clk_i(REF_CLK_I),
        .rst_n_i(RESETN_I),
        .pin_i(XTAL_I),
        .rise_o(xtal_rise)
    );

    // ****************************************
    // apb register access
    // ****************************************
    assign wr_now = PSEL_I & PENABLE_I & pready_ff & PWRITE_I;
    assign sync_stat = ton_ff & (presc_ff < SYNC_WINDOW);

    always_comb
    begin
        nxt_pready = PSEL_I & ~PENABLE_I;
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h0000_0000;
        if (PSEL_I && !PENABLE_I)
        begin
            if (PADDR_I == ADDR_ALARM_CFG)
            begin
                nxt_prdata[CFG_EN_BIT] = en_ff;
                nxt_prdata[CFG_ENDLESS_REPEAT_BIT] = endless_repeat_ff;
                nxt_prdata[CFG_MASK_HI:CFG_MASK_LO] = mask_ff;
                nxt_prdata[CFG_RPT_HI:0] = rpt_ff;
            end
            else if (PADDR_I == ADDR_CLOCK_CFG)
            begin
                nxt_prdata[CLK_WREN_BIT] = wren_ff;
                nxt_prdata[CLK_TON_BIT] = ton_ff;
                nxt_prdata[CLK_SYNC_BIT] = sync_stat;
                nxt_prdata[CAL_HI:0] = cal_ff;
            end
            else if (PADDR_I == ADDR_ALARM_MD)
                nxt_prdata[15:0] = md_ff & 16'h1F3F;
            else if (PADDR_I == ADDR_ALARM_WDH)
                nxt_prdata[15:0] = wdh_ff & 16'h073F;
            else if (PADDR_I == ADDR_ALARM_MS)
                nxt_prdata[15:0] = ms_ff & 16'h7F7F;
            else
                nxt_pslverr = 1'b1;
        end
    end

    always_comb
    begin
        nxt_wren = wren_ff;
        nxt_ton = ton_ff;
        nxt_cal = cal_ff;
        nxt_md = md_ff;
        nxt_wdh = wdh_ff;
        nxt_ms = ms_ff;
        nxt_endless_repeat = endless_repeat_ff;
        nxt_mask = mask_ff;
        nxt_en = en_ff;
        nxt_rpt = rpt_ff;
        if (wr_now)
        begin
            if (PADDR_I == ADDR_ALARM_CFG)
            begin
                nxt_en = PWDATA_I[CFG_EN_BIT];
                nxt_endless_repeat = PWDATA_I[CFG_ENDLESS_REPEAT_BIT];
                nxt_mask = PWDATA_I[CFG_MASK_HI:CFG_MASK_LO];
                nxt_rpt = PWDATA_I[CFG_RPT_HI:0];
            end
            else if (PADDR_I == ADDR_CLOCK_CFG)
            begin
                nxt_wren = PWDATA_I[CLK_WREN_BIT];
                nxt_ton = PWDATA_I[CLK_TON_BIT];
                nxt_cal = PWDATA_I[CAL_HI:0];
            end
            else if (PADDR_I == ADDR_ALARM_MD && wren_ff)
                nxt_md = PWDATA_I[15:0] & 16'h1F3F;
            else if (PADDR_I == ADDR_ALARM_WDH && wren_ff)
                nxt_wdh = PWDATA_I[15:0] & 16'h073F;
            else if (PADDR_I == ADDR_ALARM_MS && wren_ff)
                nxt_ms = PWDATA_I[15:0] & 16'h7F7F;
        end
        // alarm event outranks a same-cycle software write
        if (eval_ff && match)
        begin
            if (rpt_ff != RPT_ZERO)
                nxt_rpt = rpt_ff - 8'h01;
            else if (endless_repeat_ff)
                nxt_rpt = RPT_WRAP;
            else
                nxt_en = 1'b0;
        end
    end

    // ****************************************
    // prescaler and calibration
    // ****************************************
    // positive cal shortens the reload, negative lengthens it
    assign reload = {1'b0, PRESC_TOP}
        - (17'(signed'(cal_ff)) <<< CAL_SCALE_SHIFT);

    always_comb
    begin
        nxt_presc = presc_ff;
        nxt_phase = phase_ff;
        nxt_sec_cnt = sec_cnt_ff;
        nxt_half = 1'b0;
        nxt_sec = 1'b0;
        if (ton_ff && xtal_rise)
        begin
            if (presc_ff == 16'h0000)
            begin
                nxt_half = 1'b1;
                nxt_phase = ~phase_ff;
                nxt_presc = PRESC_TOP;
                if (phase_ff)
                begin
                    nxt_sec = 1'b1;
                    if (sec_cnt_ff == SEC_PER_MIN_M1)
                    begin
                        nxt_sec_cnt = 6'h00;
                        nxt_presc = reload[15:0];
                    end
                    else
                        nxt_sec_cnt = sec_cnt_ff + 6'h01;
                end
            end
            else
                nxt_presc = presc_ff - 16'h0001;
        end
        nxt_eval = half_ff;
        nxt_eval_sec = sec_ff;
    end

    // ****************************************
    // alarm compare
    // ****************************************
    always_comb
    begin
        match = en_ff;
        if (mask_ff == MASK_HALF_SEC)
            match = match;
        else if (!eval_sec_ff || mask_ff > MASK_YEAR)
            match = 1'b0;
        if (mask_ff >= MASK_TEN_SEC && TIME_I.second_ones != ms_ff[3:0])
            match = 1'b0;
        if (mask_ff >= MASK_MIN && TIME_I.second_tens != ms_ff[6:4])
            match = 1'b0;
        if (mask_ff >= MASK_TEN_MIN && TIME_I.minute_ones != ms_ff[11:8])
            match = 1'b0;
        if (mask_ff >= MASK_HOUR && TIME_I.minute_tens != ms_ff[14:12])
            match = 1'b0;
        if (mask_ff >= MASK_DAY && {TIME_I.hour_tens, TIME_I.hour_ones} != wdh_ff[5:0])
            match = 1'b0;
        if (mask_ff == MASK_WEEK && TIME_I.weekday_digit != wdh_ff[10:8])
            match = 1'b0;
        if (mask_ff >= MASK_MONTH && {TIME_I.day_tens, TIME_I.day_ones} != md_ff[5:0])
            match = 1'b0;
        if (mask_ff == MASK_YEAR && {TIME_I.month_tens, TIME_I.month_ones} != md_ff[12:8])
            match = 1'b0;
        nxt_irq = eval_ff & match;
        nxt_pulse = pulse_ff ^ (eval_ff & match);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge REF_CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            en_ff <= 1'b0;
            endless_repeat_ff <= 1'b0;
            mask_ff <= MASK_RESET;
            rpt_ff <= RPT_RESET;
            wren_ff <= 1'b0;
            ton_ff <= 1'b0;
            cal_ff <= 8'h00;
            md_ff <= RD_ZERO;
            wdh_ff <= RD_ZERO;
            ms_ff <= RD_ZERO;
            presc_ff <= PRESC_TOP;
            phase_ff <= 1'b0;
            sec_cnt_ff <= 6'h00;
            half_ff <= 1'b0;
            sec_ff <= 1'b0;
            eval_ff <= 1'b0;
            eval_sec_ff <= 1'b0;
            irq_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
            en_ff <= nxt_en;
            endless_repeat_ff <= nxt_endless_repeat;
            mask_ff <= nxt_mask;
            rpt_ff <= nxt_rpt;
            wren_ff <= nxt_wren;
            ton_ff <= nxt_ton;
            cal_ff <= nxt_cal;
            md_ff <= nxt_md;
            wdh_ff <= nxt_wdh;
            ms_ff <= nxt_ms;
            presc_ff <= nxt_presc;
            phase_ff <= nxt_phase;
            sec_cnt_ff <= nxt_sec_cnt;
            half_ff <= nxt_half;
            sec_ff <= nxt_sec;
            eval_ff <= nxt_eval;
            eval_sec_ff <= nxt_eval_sec;
            irq_ff <= nxt_irq;
            pulse_ff <= nxt_pulse;
        end
    end

    assign PRDATA_O = prdata_ff;
    assign PREADY_O = pready_ff;
    assign PSLVERR_O = pslverr_ff;
    assign HALF_SEC_O = half_ff;
    assign SECOND_O = sec_ff;
    assign ALARM_IRQ_O = irq_ff;
    assign ALARM_PULSE_O = pulse_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESETN_I);

    chk_wdh_gated: assert property (
        wr_now && PADDR_I == ADDR_ALARM_WDH && !wren_ff |=> $stable(wdh_ff))
        else $error("weekday/hour written while write enable low");
    chk_wdh_unimpl: assert property (
        pready_ff && PSEL_I && !PWRITE_I && PADDR_I == ADDR_ALARM_WDH
        |-> PRDATA_O[15:11] == 5'h00 && PRDATA_O[7:6] == 2'h0)
        else $error("weekday/hour reserved bits not zero");
    chk_ms_unimpl: assert property (
        pready_ff && PSEL_I && PADDR_I == ADDR_ALARM_MS
        |-> PRDATA_O[15] == 1'b0 && PRDATA_O[7] == 1'b0)
        else $error("minute/second reserved bits not zero");
    chk_irq_needs_en: assert property (
        ALARM_IRQ_O |-> $past(en_ff) && $past(eval_ff))
        else $error("alarm fired while disabled");
    chk_pulse_toggle: assert property (
        ALARM_IRQ_O |-> ALARM_PULSE_O != $past(ALARM_PULSE_O))
        else $error("alarm pulse did not toggle");
    chk_pulse_hold: assert property (
        !ALARM_IRQ_O |-> $stable(ALARM_PULSE_O))
        else $error("alarm pulse moved without alarm");
    chk_single_shot: assert property (
        eval_ff && match && rpt_ff == RPT_ZERO && !endless_repeat_ff |=> !en_ff)
        else $error("enable not cleared after last alarm");
    chk_rpt_dec: assert property (
        eval_ff && match && rpt_ff != RPT_ZERO |=> rpt_ff == $past(rpt_ff) - 8'h01)
        else $error("repeat count not decremented");
    chk_endless_repeat_wrap: assert property (
        eval_ff && match && rpt_ff == RPT_ZERO && endless_repeat_ff |=> rpt_ff == RPT_WRAP && en_ff)
        else $error("endless_repeat did not wrap repeat count");
    chk_cal_reload: assert property (
        sec_ff && sec_cnt_ff == 6'h00 |-> presc_ff == reload[15:0])
        else $error("calibration not applied at minute");
    chk_half_sec: assert property (
        eval_ff && en_ff && mask_ff == MASK_HALF_SEC |=> ALARM_IRQ_O)
        else $error("half second alarm missed");

    cov_alarm: cover property (ALARM_IRQ_O);
    cov_endless_repeat: cover property (eval_ff && match && endless_repeat_ff && rpt_ff == RPT_ZERO);
    cov_minute: cover property (sec_ff && sec_cnt_ff == 6'h00);
    cov_err: cover property (PSLVERR_O && PREADY_O);

endmodule
`default_nettype wire

// file: core/rac_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser with rising edge pulse
module rac_pin_sync
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic rise_o
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign rise_o = sync_ff & ~last_ff;

endmodule
`default_nettype wire

// file: core/rac_pkg.sv
package rac_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_ALARM_CFG = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_CFG = 8'h04;
    localparam logic [7:0] ADDR_ALARM_MD = 8'h08;
    localparam logic [7:0] ADDR_ALARM_WDH = 8'h0C;
    localparam logic [7:0] ADDR_ALARM_MS = 8'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CFG_EN_BIT = 15;
    localparam int CFG_ENDLESS_REPEAT_BIT = 14;
    localparam int CFG_MASK_HI = 13;
    localparam int CFG_MASK_LO = 10;
    localparam int CFG_RPT_HI = 7;
    localparam int CLK_WREN_BIT = 15;
    localparam int CLK_TON_BIT = 14;
    localparam int CLK_SYNC_BIT = 12;
    localparam int CAL_HI = 7;

    // ****************************************
    // reset values and constants
    // ****************************************
    localparam logic [7:0] RPT_RESET = 8'h00;
    localparam logic [7:0] RPT_WRAP = 8'hFF;
    localparam logic [7:0] RPT_ZERO = 8'h00;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [15:0] RD_ZERO = 16'h0000;
    localparam int XTAL_HZ = 32768;
    localparam int HALF_SEC_COUNTS = XTAL_HZ / 2;
    localparam logic [15:0] PRESC_TOP = 16'(HALF_SEC_COUNTS - 1);
    localparam logic [15:0] SYNC_WINDOW = 16'h0020;
    localparam logic [5:0] SEC_PER_MIN_M1 = 6'h3B;
    localparam int CAL_SCALE_SHIFT = 2;

    // ****************************************
    // alarm mask codes
    // ****************************************
    typedef enum logic [3:0] {
        MASK_HALF_SEC = 4'b0000,
        MASK_SEC = 4'b0001,
        MASK_TEN_SEC = 4'b0010,
        MASK_MIN = 4'b0011,
        MASK_TEN_MIN = 4'b0100,
        MASK_HOUR = 4'b0101,
        MASK_DAY = 4'b0110,
        MASK_WEEK = 4'b0111,
        MASK_MONTH = 4'b1000,
        MASK_YEAR = 4'b1001
    } rac_mask_t;

    // ****************************************
    // time and alarm value carriers
    // ****************************************
    typedef struct packed {
        logic month_tens;
        logic [3:0] month_ones;
        logic [1:0] day_tens;
        logic [3:0] day_ones;
        logic [2:0] weekday_digit;
        logic [1:0] hour_tens;
        logic [3:0] hour_ones;
        logic [2:0] minute_tens;
        logic [3:0] minute_ones;
        logic [2:0] second_tens;
        logic [3:0] second_ones;
    } rac_time_t;

endpackage
